// file: src/pwg_pkg.sv
`default_nettype none
package pwg_pkg;

    // store-path widths
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned BIT_W  = 3;

    // peripheral addresses
    localparam logic [ADDR_W-1:0] CMD_ADDR = 32'hFFFFF170;
    localparam logic [ADDR_W-1:0] STATUS_ADDR   = 32'hFFFFF178;
    localparam logic [ADDR_W-1:0] CLK_CTRL_ADDR = 32'hFFFFF17C;
    localparam logic [ADDR_W-1:0] PWR_CTRL_ADDR = 32'hFFFFF180;

    // field positions and reset values
    localparam int unsigned       ERR_BIT        = 4;
    localparam int unsigned       PWR_STOP_BIT   = 1;
    localparam int unsigned       PWR_IDLE_BIT   = 2;
    localparam logic [DATA_W-1:0] CLK_CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] PWR_CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] BIT_ONE      = 8'h01;

    // store kinds
    typedef enum logic [1:0] {
        OP_STORE  = 2'h0,
        OP_SET    = 2'h1,
        OP_CLEAR  = 2'h2,
        OP_INVERT = 2'h3
    } pwg_op_type;

    // controller register offsets
    localparam logic [3:0] H_TARGET   = 4'h0;
    localparam logic [3:0] H_DATA     = 4'h1;
    localparam logic [3:0] H_GO       = 4'h2;
    localparam logic [3:0] H_STATUS   = 4'h3;
    localparam logic [3:0] H_IRQ_STAT = 4'h4;
    localparam logic [3:0] H_IRQ_EN   = 4'h5;
    localparam logic [3:0] H_IRQ_CLR  = 4'h6;

    // controller fields
    localparam int unsigned D_OP_LSB  = 8;
    localparam int unsigned D_BIT_LSB = 10;
    localparam int unsigned GO_PROT   = 0;
    localparam int unsigned GO_PLAIN  = 1;
    localparam int unsigned GO_READ   = 2;
    localparam int unsigned ST_BUSY   = 0;
    localparam int unsigned ST_STBY   = 1;
    localparam int unsigned ST_BLOCK  = 2;
    localparam int unsigned ST_RD_LSB = 8;
    localparam int unsigned EV_DONE   = 0;
    localparam int unsigned EV_READ   = 1;
    localparam int unsigned EV_WAKE   = 2;
    localparam int unsigned EV_W      = 3;

    // read-modify-write of one byte by store kind
    function automatic logic [DATA_W-1:0] apply_op(input pwg_op_type op, input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] wdata, input logic [BIT_W-1:0] bitn);
        logic [DATA_W-1:0] m;
        m = BIT_ONE << bitn;
        case (op)
            OP_SET:    return old | m;
            OP_CLEAR:  return old & ~m;
            OP_INVERT: return old ^ m;
            default:   return wdata;
        endcase
    endfunction

endpackage
`default_nettype wire

// file: src/pwg_store_if.sv
`default_nettype none
interface pwg_store_if;
    // store path
    logic                          st_valid;
    logic [pwg_pkg::ADDR_W-1:0]    st_addr;
    logic [pwg_pkg::DATA_W-1:0]    st_data;
    pwg_pkg::pwg_op_type           st_op;
    logic [pwg_pkg::BIT_W-1:0]     st_bit;
    logic                          st_dma;
    // load path
    logic                          rd_valid;
    logic [pwg_pkg::ADDR_W-1:0]    rd_addr;
    logic [pwg_pkg::DATA_W-1:0]    rd_data;
    // status back to the cpu
    logic                          int_ack_block;
    logic                          standby;
    logic                          resume_skip;

    modport dev (
        input  st_valid, st_addr, st_data, st_op, st_bit, st_dma, rd_valid, rd_addr,
        output rd_data, int_ack_block, standby, resume_skip
    );
    modport cpu (
        output st_valid, st_addr, st_data, st_op, st_bit, st_dma, rd_valid, rd_addr,
        input  rd_data, int_ack_block, standby, resume_skip
    );
endinterface
`default_nettype wire

// file: src/pwg_cpu_ctrl.sv
`default_nettype none
module pwg_cpu_ctrl (
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       sys_rst,
    input  wire logic                       clock_enable,
    // software port
    input  wire logic [3:0]                 sw_addr,
    input  wire logic [31:0]                sw_wdata,
    input  wire logic                       sw_we,
    input  wire logic                       sw_re,
    output logic [31:0]                     sw_rdata,
    output logic                            irq,
    // store path to the guard
    pwg_store_if.cpu                        bus
);

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_CMD  = 7'h02,
        S_TGT  = 7'h04,
        S_SLOT = 7'h08,
        S_WAIT = 7'h10,
        S_READ = 7'h20,
        S_RCAP = 7'h40
    } pwg_hstate_type;

    typedef struct packed {
        pwg_hstate_type                       st;
        logic [pwg_pkg::ADDR_W-1:0]           target;
        logic [pwg_pkg::DATA_W-1:0]           wdata;
        pwg_pkg::pwg_op_type                  op;
        logic [pwg_pkg::BIT_W-1:0]            bitn;
        logic [pwg_pkg::DATA_W-1:0]           rd;
        logic [pwg_pkg::EV_W-1:0]             irq_stat;
        logic [pwg_pkg::EV_W-1:0]             irq_en;
        logic [31:0]                          rdata;
    } pwg_host_type;

    localparam pwg_host_type HOST_RESET = '{st: S_IDLE, op: pwg_pkg::OP_STORE, default: '0};

    pwg_host_type            q;
    pwg_host_type            n;
    logic [pwg_pkg::EV_W-1:0] ev;
    logic [pwg_pkg::EV_W-1:0] clr;

    always_comb begin
        n   = q;
        ev  = '0;
        clr = '0;
        if (sw_we) begin
            case (sw_addr)
                pwg_pkg::H_TARGET: n.target = sw_wdata;
                pwg_pkg::H_DATA: begin
                    n.wdata = sw_wdata[pwg_pkg::DATA_W-1:0];
                    n.op    = pwg_pkg::pwg_op_type'(sw_wdata[pwg_pkg::D_OP_LSB +: 2]);
                    n.bitn  = sw_wdata[pwg_pkg::D_BIT_LSB +: pwg_pkg::BIT_W];
                end
                pwg_pkg::H_GO: begin
                    // a go while busy is dropped
                    if (q.st == S_IDLE) begin
                        if (sw_wdata[pwg_pkg::GO_PROT])
                            n.st = S_CMD;
                        else if (sw_wdata[pwg_pkg::GO_PLAIN])
                            n.st = S_TGT;
                        else if (sw_wdata[pwg_pkg::GO_READ])
                            n.st = S_READ;
                    end
                end
                pwg_pkg::H_IRQ_EN:  n.irq_en = sw_wdata[pwg_pkg::EV_W-1:0];
                pwg_pkg::H_IRQ_CLR: clr = sw_wdata[pwg_pkg::EV_W-1:0];
                default: ;
            endcase
        end
        case (q.st)
            S_CMD:  n.st = S_TGT;
            S_TGT:  n.st = S_SLOT;
            S_SLOT: begin
                if (bus.standby) begin
                    n.st = S_WAIT;
                end else begin
                    n.st = S_IDLE;
                    ev[pwg_pkg::EV_DONE] = 1'b1;
                end
            end
            S_WAIT: begin
                if (bus.resume_skip) begin
                    n.st = S_IDLE;
                    ev[pwg_pkg::EV_DONE] = 1'b1;
                    ev[pwg_pkg::EV_WAKE] = 1'b1;
                end
            end
            S_READ: n.st = S_RCAP;
            S_RCAP: begin
                n.rd = bus.rd_data;
                n.st = S_IDLE;
                ev[pwg_pkg::EV_READ] = 1'b1;
            end
            default: ;
        endcase
        // an event in the clearing cycle survives
        n.irq_stat = (q.irq_stat & ~clr) | ev;
        n.rdata = '0;
        if (sw_re) begin
            case (sw_addr)
                pwg_pkg::H_TARGET: n.rdata = q.target;
                pwg_pkg::H_DATA: begin
                    n.rdata[pwg_pkg::DATA_W-1:0]               = q.wdata;
                    n.rdata[pwg_pkg::D_OP_LSB +: 2]            = q.op;
                    n.rdata[pwg_pkg::D_BIT_LSB +: pwg_pkg::BIT_W] = q.bitn;
                end
                pwg_pkg::H_STATUS: begin
                    n.rdata[pwg_pkg::ST_BUSY]  = (q.st != S_IDLE);
                    n.rdata[pwg_pkg::ST_STBY]  = bus.standby;
                    n.rdata[pwg_pkg::ST_BLOCK] = bus.int_ack_block;
                    n.rdata[pwg_pkg::ST_RD_LSB +: pwg_pkg::DATA_W] = q.rd;
                end
                pwg_pkg::H_IRQ_STAT: n.rdata[pwg_pkg::EV_W-1:0] = q.irq_stat;
                pwg_pkg::H_IRQ_EN:   n.rdata[pwg_pkg::EV_W-1:0] = q.irq_en;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst)
            q <= HOST_RESET;
        else if (clock_enable)
            q <= n;
    end

    assign bus.st_valid = (q.st == S_CMD) || (q.st == S_TGT);
    assign bus.st_addr  = (q.st == S_CMD) ? pwg_pkg::CMD_ADDR : q.target;
    assign bus.st_data  = q.wdata;
    assign bus.st_op    = (q.st == S_CMD) ? pwg_pkg::OP_STORE : q.op;
    assign bus.st_bit   = q.bitn;
    assign bus.st_dma   = 1'b0;
    assign bus.rd_valid = (q.st == S_READ);
    assign bus.rd_addr  = q.target;
    assign sw_rdata     = q.rdata;
    assign irq          = |(q.irq_stat & q.irq_en);

endmodule
`default_nettype wire

// file: src/pwg_guard.sv
`default_nettype none
module pwg_guard (
    // clock and reset
    input  wire logic                         clock,
    input  wire logic                         sys_rst,
    input  wire logic                         clock_enable,
    // cpu store path
    pwg_store_if.dev                          bus,
    // wake request from the interrupt logic, asynchronous
    input  wire logic                         wake_event,
    // guarded register contents and the protection error flag
    output logic [pwg_pkg::DATA_W-1:0]        clock_control,
    output logic [pwg_pkg::DATA_W-1:0]        power_save_control,
    output logic                              protection_error
);

    typedef struct packed {
        logic                                 armed;
        logic [pwg_pkg::DATA_W-1:0]           clk_ctrl;
        logic [pwg_pkg::DATA_W-1:0]           pwr_ctrl;
        logic                                 err;
        logic                                 standby;
        logic                                 resume;
        logic                                 wake_s1;
        logic                                 wake_s2;
        logic [pwg_pkg::DATA_W-1:0]           rdata;
    } pwg_guard_type;

    localparam pwg_guard_type GUARD_RESET = '{
        clk_ctrl: pwg_pkg::CLK_CTRL_RESET,
        pwr_ctrl: pwg_pkg::PWR_CTRL_RESET,
        default:  '0
    };

    pwg_guard_type              q;
    pwg_guard_type              n;
    logic                       st_live;
    logic                       hit_cmd;
    logic                       hit_clk;
    logic                       hit_pwr;
    logic                       hit_guarded;
    logic                       hit_status;
    logic                       err_set;
    logic                       err_clr;
    logic                       stby_req;
    logic [pwg_pkg::DATA_W-1:0] status_view;
    logic [pwg_pkg::DATA_W-1:0] status_new;
    logic [pwg_pkg::DATA_W-1:0] clk_new;
    logic [pwg_pkg::DATA_W-1:0] pwr_new;

    // dma stores are dropped
    // a dropped store does not touch the arming either, so a
    // stray transfer cannot break a sequence in progress
    assign st_live = bus.st_valid && !bus.st_dma;

    assign hit_cmd = (bus.st_addr == pwg_pkg::CMD_ADDR);
    assign hit_clk     = (bus.st_addr == pwg_pkg::CLK_CTRL_ADDR);
    assign hit_pwr     = (bus.st_addr == pwg_pkg::PWR_CTRL_ADDR);
    assign hit_guarded = hit_clk || hit_pwr;
    assign hit_status  = (bus.st_addr == pwg_pkg::STATUS_ADDR);

    // status byte as software sees it; other bits read zero
    always_comb begin
        status_view = '0;
        status_view[pwg_pkg::ERR_BIT] = q.err;
    end

    assign status_new = pwg_pkg::apply_op(bus.st_op, status_view, bus.st_data, bus.st_bit);

    // store or bit operation
    // the new byte is worked out on every store; it only lands when armed
    assign clk_new = pwg_pkg::apply_op(bus.st_op, q.clk_ctrl, bus.st_data, bus.st_bit);
    assign pwr_new = pwg_pkg::apply_op(bus.st_op, q.pwr_ctrl, bus.st_data, bus.st_bit);

    // either low-power bit in the new byte asks for standby
    assign stby_req = pwr_new[pwg_pkg::PWR_STOP_BIT] || pwr_new[pwg_pkg::PWR_IDLE_BIT];

    always_comb begin
        n       = q;
        err_set = 1'b0;
        err_clr = 1'b0;
        n.resume = 1'b0;

        // wake pin synchroniser
        n.wake_s1 = wake_event;
        n.wake_s2 = q.wake_s1;

        if (q.standby && q.wake_s2) begin
            n.standby = 1'b0;
            n.resume  = 1'b1;
        end

        if (st_live) begin
            // any store consumes the arming
            n.armed = 1'b0;
            if (hit_cmd) begin
                n.armed = 1'b1;
            end else if (hit_guarded) begin
                if (q.armed) begin
                    if (hit_clk)
                        n.clk_ctrl = clk_new;
                    else
                        n.pwr_ctrl = pwr_new;
                    // power-save entry holds the cpu
                    if (hit_pwr && stby_req)
                        n.standby = 1'b1;
                end else begin
                    err_set = 1'b1;
                end
            end else begin
                if (q.armed)
                    err_set = 1'b1;
                if (hit_status && !status_new[pwg_pkg::ERR_BIT])
                    err_clr = 1'b1;
            end
        end

        if (err_set)
            n.err = 1'b1;
        else if (err_clr)
            n.err = 1'b0;

        if (bus.rd_valid) begin
            case (bus.rd_addr)
                pwg_pkg::CLK_CTRL_ADDR: n.rdata = q.clk_ctrl;
                pwg_pkg::PWR_CTRL_ADDR: n.rdata = q.pwr_ctrl;
                pwg_pkg::STATUS_ADDR:   n.rdata = status_view;
                // the command register has no readable content
                default:                n.rdata = '0;
            endcase
        end else begin
            n.rdata = '0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst)
            q <= GUARD_RESET;
        else if (clock_enable)
            q <= n;
    end

    assign bus.int_ack_block = q.armed;

    assign protection_error = q.err;

    // the slot after the power-save store is never executed on release
    assign bus.resume_skip = q.resume;
    assign bus.standby     = q.standby;
    assign bus.rd_data     = q.rdata;

    // guarded bytes leave straight from their flip-flops
    assign clock_control      = q.clk_ctrl;
    assign power_save_control = q.pwr_ctrl;

endmodule
`default_nettype wire

// file: dv/pwg_properties.sv
`default_nettype none
module pwg_chk (
    // clock and reset
    input wire logic                         clock,
    input wire logic                         sys_rst,
    // store and load path
    input wire logic                         st_valid,
    input wire logic [pwg_pkg::ADDR_W-1:0]   st_addr,
    input wire logic                         st_dma,
    input wire logic                         rd_valid,
    input wire logic [pwg_pkg::ADDR_W-1:0]   rd_addr,
    input wire logic [pwg_pkg::DATA_W-1:0]   rd_data,
    // guard status
    input wire logic                         int_ack_block,
    input wire logic                         standby,
    input wire logic                         resume_skip
);
    timeunit 1ns;
    timeprecision 1ps;
    logic is_cmd;
    logic known_rd;
    assign is_cmd   = st_valid && !st_dma && st_addr == pwg_pkg::CMD_ADDR;
    assign known_rd = rd_addr == pwg_pkg::CLK_CTRL_ADDR || rd_addr == pwg_pkg::PWR_CTRL_ADDR ||
                      rd_addr == pwg_pkg::STATUS_ADDR;
    default clocking @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    a_block_after_cmd: assert property (is_cmd |=> int_ack_block)
        else $error("interrupt block missing after command store");
    a_block_released: assert property (st_valid && !st_dma && !is_cmd |=> !int_ack_block)
        else $error("interrupt block kept after a following store");
    a_block_has_cause: assert property ($rose(int_ack_block) |-> $past(is_cmd))
        else $error("interrupt block raised without command store");
    a_load_idle_zero: assert property (!rd_valid |=> rd_data == 8'h00)
        else $error("load data not zero outside its cycle");
    a_other_load_zero: assert property (rd_valid && !known_rd |=> rd_data == 8'h00)
        else $error("load from unguarded address not zero");
    a_standby_needs_arm: assert property ($rose(standby) |-> $past(st_valid && st_addr == pwg_pkg::PWR_CTRL_ADDR && int_ack_block))
        else $error("standby entered without armed power save store");
    a_skip_single_pulse: assert property (resume_skip |=> !resume_skip)
        else $error("resume skip longer than one cycle");
    a_skip_ends_standby: assert property (resume_skip |-> !standby && $past(standby))
        else $error("resume skip without leaving standby");
    a_no_dma_store: assert property (st_valid |-> !st_dma)
        else $error("store marked as dma");

    c_armed_pair: cover property (is_cmd ##1 st_valid && st_addr == pwg_pkg::CLK_CTRL_ADDR);
    c_wake: cover property (resume_skip);
    c_load: cover property (rd_valid ##1 rd_data != 8'h00);
endmodule
`default_nettype wire

// file: dv/protected_register_write_guard_bench.sv
`default_nettype none
module protected_register_write_guard_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock;
    logic        sys_rst;
    logic        wake_event;
    logic [3:0]  sw_addr;
    logic [31:0] sw_wdata;
    logic        sw_we;
    logic        sw_re;
    logic [31:0] sw_rdata;
    logic        irq;
    logic [7:0]  clk_ctrl;
    logic [7:0]  pwr_ctrl;
    logic        perr;
    logic [31:0] v;
    logic [31:0] seen;
    logic [2:0]  irq_en;
    logic [31:0] dw [4] = '{32'h000000A5, 32'h00000500, 32'h00000200, 32'h00001F00};
    logic [7:0]  ew [4] = '{8'hA5, 8'hA7, 8'hA6, 8'h26};
    int          err_count;
    int          cmp_count;
    int          cycles;

    pwg_store_if bus_if ();
    pwg_cpu_ctrl i_pwg_cpu_ctrl (.clock(clock), .sys_rst(sys_rst), .clock_enable(1'b1), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata), .irq(irq), .bus(bus_if.cpu));
    pwg_guard i_pwg_guard (.clock(clock), .sys_rst(sys_rst), .clock_enable(1'b1), .bus(bus_if.dev),
        .wake_event(wake_event), .clock_control(clk_ctrl), .power_save_control(pwr_ctrl), .protection_error(perr));
    pwg_chk i_pwg_chk (.clock(clock), .sys_rst(sys_rst), .st_valid(bus_if.st_valid), .st_addr(bus_if.st_addr),
        .st_dma(bus_if.st_dma), .rd_valid(bus_if.rd_valid), .rd_addr(bus_if.rd_addr), .rd_data(bus_if.rd_data),
        .int_ack_block(bus_if.int_ack_block), .standby(bus_if.standby), .resume_skip(bus_if.resume_skip));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic ck(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_we    <= 1'b1;
        @(posedge clock);
        sw_we <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        sw_addr <= a;
        sw_re   <= 1'b1;
        @(posedge clock);
        sw_re <= 1'b0;
        #1;
        d = sw_rdata;
    endtask

    // poll for an event, check the interrupt level against the mask, then clear
    task automatic await(input int ev);
        int n;
        n = 0;
        v = 32'h0;
        while (v[ev] !== 1'b1 && n < 40) begin
            rd(pwg_pkg::H_IRQ_STAT, v);
            n++;
        end
        seen = v;
        ck("event", 32'h1, 32'(v[ev]));
        ck("irq raised", 32'(irq_en[ev]), 32'(irq));
        wr(pwg_pkg::H_IRQ_CLR, 32'h7);
        rd(pwg_pkg::H_IRQ_STAT, v);
        ck("irq cleared", 32'h0, 32'(irq));
    endtask

    task automatic start(input logic [31:0] t, input logic [31:0] d, input int g);
        wr(pwg_pkg::H_TARGET, t);
        wr(pwg_pkg::H_DATA, d);
        wr(pwg_pkg::H_GO, 32'h1 << g);
    endtask

    task automatic go(input logic [31:0] t, input logic [31:0] d, input int g);
        start(t, d, g);
        await(pwg_pkg::EV_DONE);
    endtask

    task automatic devrd(input logic [31:0] t, input logic [7:0] exp);
        start(t, 32'h0, pwg_pkg::GO_READ);
        await(pwg_pkg::EV_READ);
        rd(pwg_pkg::H_STATUS, v);
        ck("load byte", 32'(exp), 32'(v[15:8]));
    endtask

    task automatic seten(input logic [2:0] e);
        irq_en = e;
        wr(pwg_pkg::H_IRQ_EN, 32'(e));
        rd(pwg_pkg::H_IRQ_EN, v);
        ck("irq enable", 32'(e), v);
    endtask

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // hang guard: whole sequence needs a few hundred cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        sys_rst = 1'b1;
        wake_event = 1'b0;
        sw_addr = 4'h0;
        sw_wdata = 32'h0;
        sw_we = 1'b0;
        sw_re = 1'b0;
        irq_en = 3'h0;
        err_count = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        ck("reset error", 32'h0, 32'(perr));
        ck("reset clock", 32'(pwg_pkg::CLK_CTRL_RESET), 32'(clk_ctrl));
        ck("reset power", 32'(pwg_pkg::PWR_CTRL_RESET), 32'(pwr_ctrl));
        rd(pwg_pkg::H_STATUS, v);
        ck("reset status", 32'h0, v);
        seten(3'h6);
        for (int i = 0; i < 4; i++) begin
            go(pwg_pkg::CLK_CTRL_ADDR, dw[i], pwg_pkg::GO_PROT);
            ck("clock control", 32'(ew[i]), 32'(clk_ctrl));
        end
        ck("no error", 32'h0, 32'(perr));
        devrd(pwg_pkg::CLK_CTRL_ADDR, 8'h26);
        devrd(pwg_pkg::CMD_ADDR, 8'h00);
        seten(3'h1);
        go(pwg_pkg::CLK_CTRL_ADDR, 32'h5A, pwg_pkg::GO_PLAIN);
        ck("unarmed kept", 32'h26, 32'(clk_ctrl));
        ck("unarmed error", 32'h1, 32'(perr));
        devrd(pwg_pkg::STATUS_ADDR, 8'h10);
        go(pwg_pkg::CLK_CTRL_ADDR, 32'h11, pwg_pkg::GO_PROT);
        ck("armed write", 32'h11, 32'(clk_ctrl));
        ck("error sticky", 32'h1, 32'(perr));
        go(pwg_pkg::STATUS_ADDR, 32'h0, pwg_pkg::GO_PLAIN);
        ck("error cleared", 32'h0, 32'(perr));
        go(pwg_pkg::CMD_ADDR, 32'h3C, pwg_pkg::GO_PLAIN);
        rd(pwg_pkg::H_STATUS, v);
        ck("block held", 32'h1, 32'(v[pwg_pkg::ST_BLOCK]));
        go(32'hFFFFF2F2, 32'h5A, pwg_pkg::GO_PLAIN);
        ck("armed other", 32'h1, 32'(perr));
        ck("other kept", 32'h11, 32'(clk_ctrl));
        go(pwg_pkg::STATUS_ADDR, 32'h0, pwg_pkg::GO_PLAIN);
        go(pwg_pkg::CMD_ADDR, 32'hC3, pwg_pkg::GO_PLAIN);
        go(pwg_pkg::CLK_CTRL_ADDR, 32'h77, pwg_pkg::GO_PLAIN);
        ck("dummy command", 32'h77, 32'(clk_ctrl));
        ck("dummy no error", 32'h0, 32'(perr));
        go(pwg_pkg::PWR_CTRL_ADDR, 32'h02, pwg_pkg::GO_PLAIN);
        ck("power kept", 32'h0, 32'(pwr_ctrl));
        ck("power error", 32'h1, 32'(perr));
        go(pwg_pkg::STATUS_ADDR, 32'h0, pwg_pkg::GO_PLAIN);
        seten(3'h5);
        start(pwg_pkg::PWR_CTRL_ADDR, 32'h02, pwg_pkg::GO_PROT);
        repeat (3) @(posedge clock);
        rd(pwg_pkg::H_STATUS, v);
        ck("standby set", 32'h1, 32'(v[pwg_pkg::ST_STBY]));
        ck("power written", 32'h02, 32'(pwr_ctrl));
        wake_event <= 1'b1;
        await(pwg_pkg::EV_DONE);
        wake_event <= 1'b0;
        ck("wake seen", 32'h1, 32'(seen[pwg_pkg::EV_WAKE]));
        rd(pwg_pkg::H_STATUS, v);
        ck("standby left", 32'h0, 32'(v[pwg_pkg::ST_STBY]));
        ck("final error", 32'h0, 32'(perr));
        final_report();
    end
endmodule
`default_nettype wire
